/* File: src/pieb_irq_enable_bank_regs.vh */
// register map, field layout and reset values of the peripheral interrupt enable bank
`ifndef PIEB_IRQ_ENABLE_BANK_REGS_VH
`define PIEB_IRQ_ENABLE_BANK_REGS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define PIEB_ADDR_W        4
`define PIEB_OFS_EN_BASE   32'h0000_0000
`define PIEB_OFS_FLAG_BASE 32'h0000_0004
`define PIEB_OFS_CTRL      4'h8
`define PIEB_OFS_STAT      4'h9

// ****************************************************************
// field layout
// ****************************************************************
`define PIEB_NUM_BANKS     4
`define PIEB_BANK_W        8
// implemented bits per bank, bank 3 in the low byte
`define PIEB_IMPL_MASK     32'h0FFF_7F3F
// bits that only the large variants carry
`define PIEB_LARGE_MASK    32'h088C_0000
`define PIEB_CTRL_GIE_BIT  7
`define PIEB_CTRL_PERIPH_MASTER_IRQ_ENABLE_BIT 6
`define PIEB_STAT_PREQ_BIT 0
`define PIEB_STAT_CREQ_BIT 1

// ****************************************************************
// reset values
// ****************************************************************
`define PIEB_RST_BYTE      8'h00
`define PIEB_RST_BIT       1'b0

`endif

/* File: src/pieb_irq_enable_bank.v */
// peripheral interrupt enable bank with pending flags, master enables and request logic
`timescale 1ns/1ps
`default_nettype none
`include "pieb_irq_enable_bank_regs.vh"

module pieb_irq_enable_bank #(
    parameter LARGE_VARIANT = 1
) (
    input  wire        clock,
    input  wire        rst_n,
    input  wire [3:0]  regAddr,
    input  wire [7:0]  regWrData,
    input  wire        regWrStb,
    input  wire        regRdStb,
    output wire [7:0]  regRdData,
    input  wire [31:0] srcEvent,
    output wire [31:0] pendingFlags,
    output wire [31:0] enableBits,
    output wire        periphIrqReq,
    output wire        coreIrqReq
);

    // ****************************************************************
    // implemented bit mask
    // ****************************************************************
    // small variants drop the large-only bits entirely so they read as zero
    localparam [31:0] BIT_MASK = (LARGE_VARIANT != 0) ? `PIEB_IMPL_MASK
                               : (`PIEB_IMPL_MASK & ~`PIEB_LARGE_MASK);

    wire [31:0] enVec;
    wire [31:0] flagVec;

    // ****************************************************************
    // enable and flag banks
    // ****************************************************************
    genvar gb;
    generate
        for (gb = 0; gb < `PIEB_NUM_BANKS; gb = gb + 1) begin : bank
            localparam [31:0] EN_OFS   = `PIEB_OFS_EN_BASE + gb;
            localparam [31:0] FLAG_OFS = `PIEB_OFS_FLAG_BASE + gb;
            localparam [7:0]  MASK     = BIT_MASK[gb*8 +: 8];

            reg  [7:0] en_ff;
            reg  [7:0] flag_ff;
            wire       enWr   = regWrStb && (regAddr == EN_OFS[3:0]);
            wire       flagWr = regWrStb && (regAddr == FLAG_OFS[3:0]);
            wire [7:0] nxt_en;
            wire [7:0] nxt_flag;

            // bit n of each bank gates source n of that bank
            assign nxt_en = enWr ? (regWrData & MASK) : en_ff;

            // an event in the same cycle as a software clear wins
            assign nxt_flag = ((flagWr ? regWrData : flag_ff) | srcEvent[gb*8 +: 8]) & MASK;

            always @(posedge clock) begin
                if (!rst_n) begin
                    en_ff   <= `PIEB_RST_BYTE;
                    flag_ff <= `PIEB_RST_BYTE;
                end else begin
                    en_ff   <= nxt_en;
                    flag_ff <= nxt_flag;
                end
            end

            assign enVec[gb*8 +: 8]   = en_ff;
            assign flagVec[gb*8 +: 8] = flag_ff;
        end
    endgenerate

    // ****************************************************************
    // master enables
    // ****************************************************************
    reg  globalIrqEnable_ff;
    reg  periphMasterIrqEnable_ff;
    wire ctrlWr = regWrStb && (regAddr == `PIEB_OFS_CTRL);

    always @(posedge clock) begin
        if (!rst_n) begin
            globalIrqEnable_ff       <= `PIEB_RST_BIT;
            periphMasterIrqEnable_ff <= `PIEB_RST_BIT;
        end else if (ctrlWr) begin
            globalIrqEnable_ff       <= regWrData[`PIEB_CTRL_GIE_BIT];
            periphMasterIrqEnable_ff <= regWrData[`PIEB_CTRL_PERIPH_MASTER_IRQ_ENABLE_BIT];
        end
    end

    // ****************************************************************
    // request generation
    // ****************************************************************
    // registered so the request is a clean flop output; costs one cycle of latency.
    // enabling a source whose flag is already set raises the request one clock after the enable bit is loaded.
    reg  periphReq_ff;
    reg  coreReq_ff;
    wire nxt_periphReq = (|(flagVec & enVec)) && periphMasterIrqEnable_ff;
    wire nxt_coreReq   = nxt_periphReq && globalIrqEnable_ff;

    always @(posedge clock) begin
        if (!rst_n) begin
            periphReq_ff <= `PIEB_RST_BIT;
            coreReq_ff   <= `PIEB_RST_BIT;
        end else begin
            periphReq_ff <= nxt_periphReq;
            coreReq_ff   <= nxt_coreReq;
        end
    end

    // ****************************************************************
    // read port
    // ****************************************************************
    reg [7:0] rdData_ff;
    reg [7:0] nxt_rdData;

    always @* begin
        nxt_rdData = `PIEB_RST_BYTE;
        case (regAddr)
            4'h0: nxt_rdData = enVec[7:0];
            4'h1: nxt_rdData = enVec[15:8];
            4'h2: nxt_rdData = enVec[23:16];
            4'h3: nxt_rdData = enVec[31:24];
            4'h4: nxt_rdData = flagVec[7:0];
            4'h5: nxt_rdData = flagVec[15:8];
            4'h6: nxt_rdData = flagVec[23:16];
            4'h7: nxt_rdData = flagVec[31:24];
            `PIEB_OFS_CTRL: begin
                nxt_rdData[`PIEB_CTRL_GIE_BIT]  = globalIrqEnable_ff;
                nxt_rdData[`PIEB_CTRL_PERIPH_MASTER_IRQ_ENABLE_BIT] = periphMasterIrqEnable_ff;
            end
            `PIEB_OFS_STAT: begin
                nxt_rdData[`PIEB_STAT_PREQ_BIT] = periphReq_ff;
                nxt_rdData[`PIEB_STAT_CREQ_BIT] = coreReq_ff;
            end
            default: nxt_rdData = `PIEB_RST_BYTE;
        endcase
    end

    // data only valid the cycle after a read strobe; zero otherwise
    always @(posedge clock) begin
        if (!rst_n) begin
            rdData_ff <= `PIEB_RST_BYTE;
        end else if (regRdStb) begin
            rdData_ff <= nxt_rdData;
        end else begin
            rdData_ff <= `PIEB_RST_BYTE;
        end
    end

    assign regRdData    = rdData_ff;
    assign pendingFlags = flagVec;
    assign enableBits   = enVec;
    assign periphIrqReq = periphReq_ff;
    assign coreIrqReq   = coreReq_ff;

endmodule // pieb_irq_enable_bank

`default_nettype wire

/* File: verification/pieb_irq_enable_bank_chk.sv */
// assertion checker for the interrupt enable bank
`timescale 1ns/1ps
`default_nettype none
module pieb_irq_enable_bank_chk (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic [3:0]  regAddr,
    input wire logic [7:0]  regWrData,
    input wire logic        regWrStb,
    input wire logic        regRdStb,
    input wire logic [7:0]  regRdData,
    input wire logic [31:0] srcEvent,
    input wire logic [31:0] pendingFlags,
    input wire logic [31:0] enableBits,
    input wire logic        periphIrqReq,
    input wire logic        coreIrqReq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    rst_clear_a: assert property ($rose(rst_n) |-> enableBits == 32'h0) else $error("enables not cleared");
    unimpl_zero_a: assert property ((enableBits & 32'hF000_80C0) == 32'h0) else $error("unused bit set");
    bank3_wr_a: assert property (regWrStb && regAddr == 4'h0 |=>
        enableBits[7:0] == ($past(regWrData) & 8'h3F)) else $error("bank3 write");
    bank4_wr_a: assert property (regWrStb && regAddr == 4'h1 |=>
        enableBits[15:8] == ($past(regWrData) & 8'h7F)) else $error("bank4 write");
    rd_idle_a: assert property (!regRdStb |=> regRdData == 8'h00) else $error("stale read data");
    bank5_rd_a: assert property (regRdStb && regAddr == 4'h2 |=>
        regRdData == $past(enableBits[23:16])) else $error("bank5 read");
    flag_catch_a: assert property (1'b1 |=>
        (pendingFlags & $past(srcEvent) & 32'h0FFF_7F3F) == ($past(srcEvent) & 32'h0FFF_7F3F)) else $error("flag lost");
    req_cause_a: assert property (periphIrqReq |-> $past(|(pendingFlags & enableBits))) else $error("req cause");
    core_gate_a: assert property (coreIrqReq |-> periphIrqReq) else $error("core without periph");
    cover property (periphIrqReq && !coreIrqReq);
    cover property (coreIrqReq);
    cover property (regWrStb && regAddr == 4'hA);
endmodule // pieb_irq_enable_bank_chk
bind pieb_irq_enable_bank pieb_irq_enable_bank_chk chk (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .srcEvent(srcEvent),
    .pendingFlags(pendingFlags), .enableBits(enableBits), .periphIrqReq(periphIrqReq), .coreIrqReq(coreIrqReq));
`default_nettype wire

/* File: verification/pieb_event_src.sv */
// peripheral event source feeding the pending flags
`timescale 1ns/1ps
`default_nettype none
module pieb_event_src (
    input  wire logic        clock,
    input  wire logic        fire,
    input  wire logic [31:0] fireMask,
    output var  logic [31:0] srcEvent = 32'h0
);
    // one-cycle pulse, so a flag stays clear once software clears it
    always @(posedge clock) srcEvent <= fire ? fireMask : 32'h0;
endmodule // pieb_event_src
`default_nettype wire

/* File: verification/pieb_irq_enable_bank_tb_top.sv */
// self-checking bench for the interrupt enable bank
`timescale 1ns/1ps
`default_nettype none
module pieb_irq_enable_bank_tb_top;
    logic        clock = 1'b0, rst_n = 1'b0, regWrStb = 1'b0, regRdStb = 1'b0, fire = 1'b0;
    logic [3:0]  regAddr = 4'h0;
    logic [7:0]  regWrData = 8'h00, regRdData;
    logic [31:0] srcEvent, pendingFlags, enableBits, fireMask = 32'h0, lfsr = 32'h274A;
    logic        periphIrqReq, coreIrqReq;
    int          error_cnt = 0, comparisons = 0, ctl = 0, i, en[8], msk[4] = '{32'h3F, 32'h7F, 32'hFF, 32'h0F};
    pieb_irq_enable_bank uut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .srcEvent(srcEvent), .coreIrqReq(coreIrqReq),
        .pendingFlags(pendingFlags), .enableBits(enableBits), .periphIrqReq(periphIrqReq));
    pieb_event_src src (.clock(clock), .fire(fire), .fireMask(fireMask), .srcEvent(srcEvent));
    initial forever #20 clock = ~clock;
    // next state of the bench's random source, one step per call
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [1:0] st();
        int p = 0;
        for (int b = 0; b < 4; b++) p |= en[b] & en[b + 4];
        return {p != 0 && ctl[6] && ctl[7], p != 0 && ctl[6]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string nm);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        regWrStb <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clock);
        regWrStb <= 1'b0;
        if (a < 8) en[a] = d & msk[a[1:0]];
        if (a == 8) ctl = d;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        regRdStb <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRdStb <= 1'b0;
        @(negedge clock);
        chk(regRdData, a < 8 ? en[a][7:0] : (a == 9 ? {6'h0, st()} : (a == 8 ? ctl[7:0] & 8'hC0 : 8'h00)), "read");
    endtask
    task automatic req();
        repeat (2) @(posedge clock);
        @(negedge clock);
        chk({6'h0, coreIrqReq, periphIrqReq}, {6'h0, st()}, "requests");
    endtask
    task automatic conclude;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        for (i = 0; i < 16; i++) rd(i[3:0]);
        for (i = 0; i < 24; i++) begin
            lfsr = lfsr_next(lfsr);
            wr({2'b00, lfsr[1:0]}, lfsr[15:8]);
            rd({2'b00, lfsr[1:0]});
        end
        wr(4'hA, 8'hFF);
        rd(4'hA);
        for (i = 4; i < 8; i++) wr(i[3:0], 8'h00);
        for (i = 0; i < 4; i++) wr(i[3:0], 8'hFF);
        @(posedge clock);
        fire <= 1'b1;
        fireMask <= 32'hFFFF_FFFF;
        @(posedge clock);
        fire <= 1'b0;
        for (i = 4; i < 8; i++) en[i] = msk[i - 4];
        req();
        for (i = 4; i < 8; i++) rd(i[3:0]);
        wr(4'h8, 8'h40);
        req();
        wr(4'h8, 8'hC0);
        req();
        rd(4'h9);
        for (i = 0; i < 12; i++) begin
            lfsr = lfsr_next(lfsr);
            wr({1'b0, lfsr[2:0]}, lfsr[15:8] & lfsr[23:16]);
            req();
        end
        // second reset in mid-run must clear every enable and flag
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        en = '{default: 0};
        ctl = 0;
        for (i = 0; i < 10; i++) rd(i[3:0]);
        conclude();
    end
endmodule // pieb_irq_enable_bank_tb_top
`default_nettype wire
